// [core/ira_pkg.sv]
package ira_pkg;
    // seven-bit target address; bit 0 of the address byte is the direction
    localparam logic [6:0] IRA_TARGET_ADDR = 7'h25;  // 0100101x
    localparam int         IRA_AW          = 8;      // register address width
    localparam int         IRA_DW          = 8;      // register data width
    localparam logic [7:0] IRA_PTR_RST     = 8'h00;  // pointer after reset
    localparam logic [3:0] IRA_BIT_LAST    = 4'h7;   // index of eighth data bit
    localparam logic [3:0] IRA_BIT_ACK     = 4'h8;   // index of ack clock

    typedef enum {
        IRA_IDLE,
        IRA_ADDR,
        IRA_ADDR_ACK,
        IRA_REG,
        IRA_REG_ACK,
        IRA_WDATA,
        IRA_WDATA_ACK,
        IRA_RDATA,
        IRA_RDATA_ACK
    } ira_state_t;
endpackage

// [core/ira_sync.sv]
`timescale 1ns/1ps
// three-stage synchroniser; output changes only when stages two and three agree
module ira_sync (
    input  wire logic clock_i,    // system clock
    input  wire logic reset_n_i,  // async reset, active low
    input  wire logic async_i,    // pin level
    output logic      level_o     // filtered level
);
    logic [2:0] sh_r;
    logic [2:0] sh_nxt;
    logic       lvl_r;
    logic       lvl_nxt;

    // stage one is read only by stage two
    always_comb
    begin
        sh_nxt  = {sh_r[1:0], async_i};
        lvl_nxt = (sh_r[1] == sh_r[2]) ? sh_r[2] : lvl_r;
    end

    // idle bus level is high, so reset to one
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sh_r  <= 3'h7;
            lvl_r <= 1'b1;
        end
        else
        begin
            sh_r  <= sh_nxt;
            lvl_r <= lvl_nxt;
        end
    end

    assign level_o = lvl_r;
endmodule // ira_sync

// [core/ira_slave.sv]
`timescale 1ns/1ps
// Summary of operation
// - the first byte after the address in a write is loaded into the register pointer.
// - a stop right after the register address byte leaves only the new pointer behind.
// - the first data byte goes to the pointed register and each next byte to the next one.
// - the pointer increments after each stored write byte until the stop.
// - reads return the register selected by the same shared pointer.
// - the pointer increments after every byte transmitted in a read.
// - after a not-acknowledge the device stops sending and releases the data line.
// - only address bytes 01001010 (write) and 01001011 (read) are answered.
// - the device holds the data line low during the ninth clock of its own address byte and of each byte written to it.
module ira_slave
    import ira_pkg::*;
#(
    parameter int AW = ira_pkg::IRA_AW,  // register address width
    parameter int DW = ira_pkg::IRA_DW   // register data width
) (
    input  wire logic          clock_i,    // 200 MHz system clock
    input  wire logic          reset_n_i,  // async reset, active low
    input  wire logic          scl_i,      // serial clock pin
    input  wire logic          sda_i,      // serial data pin level
    output logic               sda_o,      // data drive value, always low
    output logic               sda_oe_o,   // high while pulling data low
    output logic [AW-1:0]      reg_addr_o, // register pointer
    output logic [DW-1:0]      wr_data_o,  // data for a register write
    output logic               wr_stb_o,   // one-cycle write strobe
    output logic               rd_stb_o,   // one-cycle read strobe
    input  wire logic [DW-1:0] rd_data_i,  // register content at reg_addr_o
    output logic               busy_o      // addressed transaction running
);
    import ira_pkg::*;

    logic            scl_s;
    logic            sda_s;
    logic            scl_d_r;
    logic            sda_d_r;
    ira_state_t      st_r,    st_nxt;
    logic [3:0]      bit_r,   bit_nxt;
    logic [7:0]      sh_r,    sh_nxt;
    logic [AW-1:0]   ptr_r,   ptr_nxt;
    logic [DW-1:0]   wd_r,    wd_nxt;
    logic            wst_r,   wst_nxt;
    logic            rst_r,   rst_nxt;
    logic            oe_r,    oe_nxt;
    logic            busy_r,  busy_nxt;
    logic            rise;
    logic            fall;
    logic            start_c;
    logic            stop_c;

    ira_sync u_scl (.clock_i(clock_i), .reset_n_i(reset_n_i), .async_i(scl_i), .level_o(scl_s));
    ira_sync u_sda (.clock_i(clock_i), .reset_n_i(reset_n_i), .async_i(sda_i), .level_o(sda_s));

    // edge and bus condition detection on filtered levels
    assign rise    = scl_s & ~scl_d_r;
    assign fall    = ~scl_s & scl_d_r;
    assign start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_c  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // byte engine: sample on rising clock, change drive on falling clock
    always_comb
    begin
        st_nxt   = st_r;
        bit_nxt  = bit_r;
        sh_nxt   = sh_r;
        ptr_nxt  = ptr_r;
        wd_nxt   = wd_r;
        wst_nxt  = 1'b0;
        rst_nxt  = 1'b0;
        oe_nxt   = oe_r;
        busy_nxt = busy_r;
        if (start_c)
        begin
            // repeated start also lands here; pointer is kept
            st_nxt   = IRA_ADDR;
            bit_nxt  = 4'h0;
            oe_nxt   = 1'b0;
            busy_nxt = 1'b0;
        end
        else if (stop_c)
        begin
            // stop after register byte leaves only the pointer
            st_nxt   = IRA_IDLE;
            oe_nxt   = 1'b0;
            busy_nxt = 1'b0;
        end
        else
        begin
            case (st_r)
                IRA_IDLE: ;
                IRA_ADDR, IRA_REG, IRA_WDATA:
                begin
                    if (rise)
                    begin
                        sh_nxt  = {sh_r[6:0], sda_s};
                        bit_nxt = bit_r + 4'h1;
                    end
                    if (fall && bit_r == IRA_BIT_ACK)
                    begin
                        bit_nxt = 4'h0;
                        if (st_r == IRA_ADDR)
                        begin
                            if (sh_r[7:1] == IRA_TARGET_ADDR)
                            begin
                                oe_nxt   = 1'b1;
                                busy_nxt = 1'b1;
                                st_nxt   = IRA_ADDR_ACK;
                            end
                            else
                                st_nxt = IRA_IDLE;
                        end
                        else if (st_r == IRA_REG)
                        begin
                            ptr_nxt = sh_r[AW-1:0];
                            oe_nxt  = 1'b1;
                            st_nxt  = IRA_REG_ACK;
                        end
                        else
                        begin
                            wd_nxt  = sh_r[DW-1:0];
                            wst_nxt = 1'b1;
                            oe_nxt  = 1'b1;
                            st_nxt  = IRA_WDATA_ACK;
                        end
                    end
                end
                IRA_ADDR_ACK, IRA_REG_ACK, IRA_WDATA_ACK:
                begin
                    if (fall)
                    begin
                        oe_nxt  = 1'b0;
                        bit_nxt = 4'h0;
                        if (st_r == IRA_WDATA_ACK)
                            ptr_nxt = ptr_r + 1'b1;
                        if (st_r == IRA_ADDR_ACK && sh_r[0])
                        begin
                            // first read bit goes out now
                            sh_nxt  = rd_data_i;
                            oe_nxt  = ~rd_data_i[7];
                            rst_nxt = 1'b1;
                            st_nxt  = IRA_RDATA;
                        end
                        else if (st_r == IRA_ADDR_ACK)
                            st_nxt = IRA_REG;
                        else
                            st_nxt = IRA_WDATA;
                    end
                end
                IRA_RDATA:
                begin
                    if (fall)
                    begin
                        bit_nxt = bit_r + 4'h1;
                        if (bit_r == IRA_BIT_LAST)
                        begin
                            oe_nxt  = 1'b0;  // let the controller answer
                            ptr_nxt = ptr_r + 1'b1;
                            st_nxt  = IRA_RDATA_ACK;
                        end
                        else
                        begin
                            sh_nxt = {sh_r[6:0], 1'b0};
                            oe_nxt = ~sh_r[6];
                        end
                    end
                end
                IRA_RDATA_ACK:
                begin
                    if (rise && sda_s)
                        st_nxt = IRA_IDLE; // not-acknowledge: release
                    else if (fall)
                    begin
                        // acknowledged: the shift register no longer holds the
                        // direction bit, so the next byte is launched here
                        bit_nxt = 4'h0;
                        sh_nxt  = rd_data_i;
                        oe_nxt  = ~rd_data_i[7];
                        rst_nxt = 1'b1;
                        st_nxt  = IRA_RDATA;
                    end
                end
                default: st_nxt = IRA_IDLE;
            endcase
        end
    end

    // state registers; every output except sda_o comes straight from these flops
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            st_r    <= IRA_IDLE;
            bit_r   <= 4'h0;
            sh_r    <= 8'h00;
            ptr_r   <= IRA_PTR_RST;
            wd_r    <= '0;
            wst_r   <= 1'b0;
            rst_r   <= 1'b0;
            oe_r    <= 1'b0;
            busy_r  <= 1'b0;
        end
        else
        begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            st_r    <= st_nxt;
            bit_r   <= bit_nxt;
            sh_r    <= sh_nxt;
            ptr_r   <= ptr_nxt;
            wd_r    <= wd_nxt;
            wst_r   <= wst_nxt;
            rst_r   <= rst_nxt;
            oe_r    <= oe_nxt;
            busy_r  <= busy_nxt;
        end
    end

    // open drain: value is constant low, only the enable moves
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            sda_o <= 1'b0;
        else
            sda_o <= 1'b0;
    end

    assign sda_oe_o   = oe_r;
    assign reg_addr_o = ptr_r;
    assign wr_data_o  = wd_r;
    assign wr_stb_o   = wst_r;
    assign rd_stb_o   = rst_r;
    assign busy_o     = busy_r;

    // a write strobe comes in the same cycle as the acknowledge drive on the data line
    AST_WR_ACK: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wst_r |-> oe_r) else $error("write byte not acknowledged");
    AST_PTR_LOAD: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (st_r == IRA_REG_ACK && $past(st_r) == IRA_REG) |-> ptr_r == $past(sh_r))
        else $error("pointer not loaded from register byte");
    AST_WR_INC: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (st_r == IRA_WDATA_ACK && st_nxt == IRA_WDATA && !start_c && !stop_c)
        |=> ptr_r == $past(ptr_r) + 1'b1) else $error("write pointer not stepped");
    AST_RD_INC: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (st_r == IRA_RDATA && st_nxt == IRA_RDATA_ACK)
        |=> ptr_r == $past(ptr_r) + 1'b1) else $error("read pointer not stepped");
    AST_NACK_REL: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (st_r == IRA_RDATA_ACK && rise && sda_s && !start_c && !stop_c)
        |=> !oe_r && st_r == IRA_IDLE) else $error("line held after nack");
    AST_STOP_KEEP: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        stop_c |=> !wst_r && ptr_r == $past(ptr_r)) else $error("stop changed state");
    AST_NO_DRIVE_IDLE: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (st_r == IRA_IDLE) |-> !oe_r) else $error("drive while idle");
    AST_RD_SRC: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        rst_r |-> sh_r == $past(rd_data_i)) else $error("read data not from pointer");
    AST_PTR_HOLD: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (st_r == IRA_IDLE && st_nxt == IRA_IDLE) |=> ptr_r == $past(ptr_r))
        else $error("pointer moved between transactions");
    AST_WR_FIRST: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wst_r |-> wd_r == $past(sh_r[DW-1:0]) && ptr_r == $past(ptr_r))
        else $error("write data or address mismatch");
endmodule // ira_slave

// [bench/ira_ctl_model.sv]
`timescale 1ns/1ps
// bus controller model; the data wire has a pull-up, so releasing it reads high
module ira_ctl_model (
    input  wire logic clock_i,   // system clock, paces the bus
    input  wire logic sda_i,     // resolved data wire
    output logic      scl_o,     // serial clock, still between frames
    output logic      sda_low_o  // high while pulling data low
);
    initial
    begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic pause(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    // start or repeated start: data falls while the clock is high
    task automatic start();
        pause(6);
        sda_low_o <= 1'b0;
        pause(7);
        scl_o <= 1'b1;
        pause(6);
        sda_low_o <= 1'b1;
        pause(6);
        scl_o <= 1'b0;
    endtask

    // stop: data rises while the clock is high, then the clock stands still
    task automatic stop();
        pause(6);
        sda_low_o <= 1'b1;
        pause(7);
        scl_o <= 1'b1;
        pause(6);
        sda_low_o <= 1'b0;
        pause(12);
    endtask

    // one bit of 125 ns: data changes only while the clock is low
    task automatic bit_xfer(input logic b, output logic r);
        pause(6);
        sda_low_o <= !b;
        pause(7);
        scl_o <= 1'b1;
        pause(6);
        r = sda_i;
        pause(6);
        scl_o <= 1'b0;
    endtask

    // eight bits msb first, then the ninth clock from this side
    task automatic xfer(input logic [7:0] d, input logic ack_in,
                        output logic [7:0] q, output logic ack_out);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_xfer(d[i], r);
            q[i] = r;
        end
        bit_xfer(ack_in, ack_out);
    endtask
endmodule // ira_ctl_model

// [bench/ira_slave_tb.sv]
`timescale 1ns/1ps
module ira_slave_tb;
    import ira_pkg::*;
    logic        clock_i;
    logic        reset_n_i;
    logic        scl, ctl_low, sda_w, sda_oe, wr_stb, rd_stb, busy;
    logic        sda_dv;
    int          n_rd = 0;
    logic [7:0]  reg_addr, wr_data, rd_data;
    logic [7:0]  regs [256];
    logic [15:0] wq [$];
    int          n_mismatch = 0;
    int          checks     = 0;

    ira_slave i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_dv), .sda_oe_o(sda_oe), .reg_addr_o(reg_addr), .wr_data_o(wr_data),
        .wr_stb_o(wr_stb), .rd_stb_o(rd_stb), .rd_data_i(rd_data), .busy_o(busy));
    ira_ctl_model i_ctl (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(ctl_low));

    // wired-and with pull-up; register file answers combinationally at the pointer
    assign sda_w   = !((sda_oe && !sda_dv) || ctl_low);
    assign rd_data = regs[reg_addr];

    // user side: store strobed writes and keep a log of them
    always @(posedge clock_i)
    begin
        if (wr_stb === 1'b1)
        begin
            regs[reg_addr] <= wr_data;
            wq.push_back({reg_addr, wr_data});
        end
        if (rd_stb === 1'b1)
            n_rd <= n_rd + 1;
    end

    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    task automatic end_of_test();
        if (n_mismatch == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic [7:0] d, input logic exp_ack);
        logic [7:0] q;
        logic       a;
        i_ctl.xfer(d, 1'b1, q, a);
        chk({7'h00, a}, {7'h00, exp_ack});
    endtask

    task automatic rb(input logic [7:0] exp, input logic nack);
        logic [7:0] q;
        logic       a;
        i_ctl.xfer(8'hff, nack, q, a);
        chk(q, exp);
    endtask

    task automatic set_ptr(input logic [7:0] p, input logic with_stop);
        i_ctl.start();
        wb(8'h4a, 1'b0);
        wb(p, 1'b0);
        if (with_stop)
            i_ctl.stop();
    endtask

    // pointer-only write, then a fresh read from that pointer
    task automatic sc_ptr_then_read();
        int rd0;
        wq.delete();
        set_ptr(8'h40, 1'b1);
        chk(reg_addr, 8'h40);
        chk(8'(wq.size()), 8'h00);
        i_ctl.start();
        wb(8'h4b, 1'b0);
        chk({7'h00, busy}, 8'h01);
        rd0 = n_rd;
        rb(8'h70, 1'b0);
        rb(8'h71, 1'b1);
        i_ctl.pause(10);
        chk({7'h00, sda_oe}, 8'h00);
        chk(8'(n_rd - rd0), 8'h02);
        i_ctl.stop();
        chk(reg_addr, 8'h42);
    endtask

    // burst write across the top of the pointer range
    task automatic sc_burst_write();
        logic [7:0] d [3] = '{8'h5c, 8'ha3, 8'h31};
        wq.delete();
        set_ptr(8'hfe, 1'b0);
        for (int i = 0; i < 3; i++)
            wb(d[i], 1'b0);
        i_ctl.stop();
        chk(8'(wq.size()), 8'h03);
        for (int i = 0; i < 3 && i < wq.size(); i++)
        begin
            chk(wq[i][15:8], 8'hfe + 8'(i));
            chk(wq[i][7:0], d[i]);
        end
        chk(reg_addr, 8'h01);
    endtask

    // pointer write, repeated start, read back; next byte would drive a low msb
    task automatic sc_read_repeated_start();
        set_ptr(8'hfe, 1'b0);
        i_ctl.start();
        wb(8'h4b, 1'b0);
        rb(8'h5c, 1'b0);
        rb(8'ha3, 1'b0);
        rb(8'h31, 1'b1);
        i_ctl.pause(10);
        chk({7'h00, sda_oe}, 8'h00);
        i_ctl.stop();
        chk(reg_addr, 8'h01);
        chk({7'h00, busy}, 8'h00);
    endtask

    // foreign addresses get no acknowledge and change nothing
    task automatic sc_wrong_addr();
        logic [7:0] a [4] = '{8'h4c, 8'hca, 8'h4e, 8'h4f};
        wq.delete();
        foreach (a[i])
        begin
            i_ctl.start();
            wb(a[i], 1'b1);
            wb(8'h00, 1'b1);
            i_ctl.stop();
        end
        chk(8'(wq.size()), 8'h00);
        chk(reg_addr, 8'h01);
    endtask

    // watchdog: a hung run ends through the same report
    initial
    begin
        repeat (100000) @(posedge clock_i);
        n_mismatch++;
        $display("Error at %0t: run did not finish in time", $time);
        end_of_test();
    end

    initial
    begin
        reset_n_i = 1'b0;
        for (int i = 0; i < 256; i++)
            regs[i] = 8'(i) + 8'h30;
        repeat (6) @(posedge clock_i);
        reset_n_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        chk(reg_addr, IRA_PTR_RST);
        sc_ptr_then_read();
        sc_burst_write();
        sc_read_repeated_start();
        sc_wrong_addr();
        end_of_test();
    end
endmodule // ira_slave_tb
